// ### inc/smr_pkg.sv
package smr_pkg;
    // sleep-mode selection codes
    localparam logic [2:0] SM_IDLE = 3'h0;
    localparam logic [2:0] SM_ADCNR = 3'h1;
    localparam logic [2:0] SM_PDOWN = 3'h2;
    localparam logic [2:0] SM_PSAVE = 3'h3;
    localparam logic [2:0] SM_STBY = 3'h6;
    localparam logic [2:0] SM_XSTBY = 3'h7;
    // clock and oscillator restart timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int OSC_START_NS = 1000;
    localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] OSC_START_CNT = 6'(OSC_START_CYC);
    // pin counts and scan pin positions on the third port
    localparam int GP_PINS = 32;
    localparam int TCK_POS = 18;
    localparam int TMS_POS = 19;
    localparam int TDI_POS = 21;
    localparam logic [31:0] SCAN_PULL_MASK = 32'h002C0000;
    // controller states
    typedef enum logic [2:0] {
        SMR_RUN = 3'h1,
        SMR_SLEEP = 3'h2,
        SMR_WAKE = 3'h4
    } smr_state_t;
endpackage

// ### inc/smr_gate_if.sv
`timescale 1ns/1ns
`default_nettype none
interface smr_gate_if;
    logic [2:0] mode;
    logic asleep;
    logic waking;
    logic cpu_en;
    logic io_en;
    logic adc_en;
    logic asy_en;
    logic osc_en;
    modport dec (input mode, asleep, waking, output cpu_en, io_en, adc_en, asy_en, osc_en);
    modport ctl (output mode, asleep, waking, input cpu_en, io_en, adc_en, asy_en, osc_en);
endinterface
`default_nettype wire

// ### src/smr_gate_dec.sv
`timescale 1ns/1ns
`default_nettype none
module smr_gate_dec
    import smr_pkg::*;
(
    smr_gate_if.dec gif
);
    // per-mode clock domain gating; reserved codes never reach here asleep
    always_comb
    begin
        gif.cpu_en = 1'b1;
        gif.io_en = 1'b1;
        gif.adc_en = 1'b1;
        gif.asy_en = 1'b1;
        gif.osc_en = 1'b1;
        if (gif.waking)
        begin
            // oscillator restarting: nothing clocked but the timer
            gif.cpu_en = 1'b0;
            gif.io_en = 1'b0;
            gif.adc_en = 1'b0;
        end
        else if (gif.asleep)
        begin
            gif.cpu_en = 1'b0;
            case (gif.mode)
                SM_IDLE:
                begin
                    gif.io_en = 1'b1;
                end
                SM_ADCNR:
                begin
                    gif.io_en = 1'b0;
                end
                SM_PDOWN:
                begin
                    gif.io_en = 1'b0;
                    gif.adc_en = 1'b0;
                    gif.asy_en = 1'b0;
                    gif.osc_en = 1'b0;
                end
                SM_PSAVE:
                begin
                    gif.io_en = 1'b0;
                    gif.adc_en = 1'b0;
                    gif.osc_en = 1'b0;
                end
                SM_STBY:
                begin
                    gif.io_en = 1'b0;
                    gif.adc_en = 1'b0;
                    gif.asy_en = 1'b0;
                end
                default:
                begin
                    gif.io_en = 1'b0;
                    gif.adc_en = 1'b0;
                end
            endcase
        end
    end
endmodule // smr_gate_dec
`default_nettype wire

// ### src/smr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module smr_ctrl
    import smr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ext_rst_n,
    input wire logic sleep_req,
    input wire logic sleep_en,
    input wire logic [2:0] sleep_mode,
    input wire logic irq_ext,
    input wire logic irq_async,
    input wire logic irq_adc,
    input wire logic irq_any,
    input wire logic [31:0] port_dir,
    input wire logic [31:0] port_out,
    input wire logic [31:0] port_pull,
    input wire logic scan_en,
    input wire logic tap_shift,
    input wire logic tdo_data,
    output logic cpu_clk_en,
    output logic io_clk_en,
    output logic adc_clk_en,
    output logic asy_clk_en,
    output logic osc_en,
    output logic sleeping,
    output logic sys_rst_n,
    output logic [31:0] gp_o,
    output logic [31:0] gp_oe_n,
    output logic [31:0] gp_pull_en,
    output logic tdo_o,
    output logic tdo_oe_n
);
    smr_gate_if gif();
    smr_state_t st_r;
    smr_state_t st_nxt;
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic [5:0] wait_r;
    logic [5:0] wait_nxt;
    logic arst_n;
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_any;
    logic mode_ok;
    logic wake_hit;
    logic osc_was_off;

    smr_gate_dec u_dec (
        .gif(gif)
    );

    // either reset pin clears everything at once, no clock needed
    assign arst_n = nrst & ext_rst_n;

    // release of the internal reset is synchronised; assertion stays async
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign sys_rst_n = rst_sync_r;
    // combinational so pins float the instant a reset pin falls
    assign rst_any = ~arst_n | ~rst_sync_r;

    // reserved mode codes are refused rather than guessed at
    always_comb
    begin
        mode_ok = 1'b0;
        case (sleep_mode)
            SM_IDLE, SM_ADCNR, SM_PDOWN, SM_PSAVE, SM_STBY, SM_XSTBY:
            begin
                mode_ok = 1'b1;
            end
            default:
            begin
                mode_ok = 1'b0;
            end
        endcase
    end

    // wake sources allowed by the mode held at entry
    always_comb
    begin
        wake_hit = irq_ext;
        osc_was_off = 1'b0;
        case (mode_r)
            SM_IDLE:
            begin
                wake_hit = irq_any | irq_ext;
            end
            SM_ADCNR:
            begin
                wake_hit = irq_ext | irq_async | irq_adc;
            end
            SM_PDOWN:
            begin
                wake_hit = irq_ext;
                osc_was_off = 1'b1;
            end
            SM_PSAVE:
            begin
                wake_hit = irq_ext | irq_async;
                osc_was_off = 1'b1;
            end
            SM_STBY:
            begin
                wake_hit = irq_ext;
            end
            default:
            begin
                wake_hit = irq_ext | irq_async;
            end
        endcase
    end

    // sleep sequencer; the oscillator restart wait only follows modes that stopped it
    always_comb
    begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        wait_nxt = wait_r;
        case (st_r)
            SMR_RUN:
            begin
                if (sleep_req && sleep_en && mode_ok)
                begin
                    st_nxt = SMR_SLEEP;
                    mode_nxt = sleep_mode;
                end
            end
            SMR_SLEEP:
            begin
                if (wake_hit && osc_was_off)
                begin
                    st_nxt = SMR_WAKE;
                    wait_nxt = OSC_START_CNT;
                end
                else if (wake_hit)
                begin
                    st_nxt = SMR_RUN;
                end
            end
            SMR_WAKE:
            begin
                if (wait_r <= 6'h01)
                begin
                    st_nxt = SMR_RUN;
                    wait_nxt = 6'h00;
                end
                else
                begin
                    wait_nxt = wait_r - 6'h01;
                end
            end
            default:
            begin
                st_nxt = SMR_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= SMR_RUN;
        end
        else if (!rst_sync_r)
        begin
            st_r <= SMR_RUN;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // mode held for the whole sleep, so software changes mid-sleep do nothing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_r <= SM_IDLE;
            wait_r <= 6'h00;
        end
        else
        begin
            mode_r <= mode_nxt;
            wait_r <= wait_nxt;
        end
    end

    // decoder looks at next state so the gating flops line up with st_r
    assign gif.mode = mode_nxt;
    assign gif.asleep = (st_nxt == SMR_SLEEP) && rst_sync_r;
    assign gif.waking = (st_nxt == SMR_WAKE) && rst_sync_r;

    // registered clock enables avoid glitches on the gating cells
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cpu_clk_en <= 1'b0;
            io_clk_en <= 1'b0;
            adc_clk_en <= 1'b0;
            asy_clk_en <= 1'b1;
            osc_en <= 1'b1;
            sleeping <= 1'b0;
        end
        else
        begin
            cpu_clk_en <= gif.cpu_en & rst_sync_r;
            io_clk_en <= gif.io_en & rst_sync_r;
            adc_clk_en <= gif.adc_en & rst_sync_r;
            asy_clk_en <= gif.asy_en;
            osc_en <= gif.osc_en;
            sleeping <= gif.asleep;
        end
    end

    // pads: enable is low while driving; reset floats them with no clock
    always_comb
    begin
        gp_o = port_out;
        gp_oe_n = rst_any ? 32'hFFFFFFFF : ~port_dir;
        gp_pull_en = rst_any ? 32'h00000000 : (port_pull & ~port_dir);
        if (scan_en)
        begin
            gp_pull_en = gp_pull_en | SCAN_PULL_MASK;
        end
    end

    // test data out only drives while the controller shifts
    assign tdo_o = tdo_data;
    assign tdo_oe_n = ~(scan_en & tap_shift);

    localparam int WAKE_MAX = OSC_START_CYC;

    sequence s_enter;
        st_r == SMR_RUN && sleep_req && sleep_en && mode_ok;
    endsequence

    sequence s_asleep_in(logic [2:0] m);
        st_r == SMR_SLEEP && mode_r == m;
    endsequence

    property p_enter;
        @(posedge clk) disable iff (!nrst)
        s_enter ##0 rst_sync_r |=> st_r == SMR_SLEEP && mode_r == $past(sleep_mode);
    endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered");

    property p_no_enter;
        @(posedge clk) disable iff (!nrst)
        st_r == SMR_RUN && sleep_req && !sleep_en |=> st_r == SMR_RUN;
    endproperty
    a_no_enter: assert property (p_no_enter) else $error("slept without enable");

    property p_idle;
        @(posedge clk) disable iff (!nrst)
        s_asleep_in(SM_IDLE) |-> !cpu_clk_en && io_clk_en && adc_clk_en && sleeping;
    endproperty
    a_idle: assert property (p_idle) else $error("idle gating wrong");

    property p_pdown;
        @(posedge clk) disable iff (!nrst)
        s_asleep_in(SM_PDOWN) |-> !osc_en && !asy_clk_en && !io_clk_en && !cpu_clk_en;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down gating wrong");

    property p_psave;
        @(posedge clk) disable iff (!nrst)
        s_asleep_in(SM_PSAVE) |-> asy_clk_en && !osc_en && !io_clk_en;
    endproperty
    a_psave: assert property (p_psave) else $error("power-save gating wrong");

    property p_adcnr;
        @(posedge clk) disable iff (!nrst)
        s_asleep_in(SM_ADCNR) |-> adc_clk_en && asy_clk_en && !io_clk_en && !cpu_clk_en;
    endproperty
    a_adcnr: assert property (p_adcnr) else $error("noise-reduction gating wrong");

    property p_stby;
        @(posedge clk) disable iff (!nrst)
        s_asleep_in(SM_STBY) |-> osc_en && !asy_clk_en && !io_clk_en;
    endproperty
    a_stby: assert property (p_stby) else $error("standby gating wrong");

    property p_xstby;
        @(posedge clk) disable iff (!nrst)
        s_asleep_in(SM_XSTBY) |-> osc_en && asy_clk_en && !io_clk_en;
    endproperty
    a_xstby: assert property (p_xstby) else $error("extended standby gating wrong");

    property p_wake;
        @(posedge clk) disable iff (!nrst || !ext_rst_n)
        s_asleep_in(SM_PDOWN) ##0 irq_ext |=> st_r == SMR_WAKE ##[1:WAKE_MAX] st_r == SMR_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("power-down wake late");

    property p_ext_rst;
        @(posedge clk) disable iff (!nrst)
        !ext_rst_n |-> gp_oe_n == 32'hFFFFFFFF && !sys_rst_n;
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("reset did not float pins");

    property p_rel;
        @(posedge clk) disable iff (!nrst)
        $rose(ext_rst_n) |-> !sys_rst_n ##1 !sys_rst_n ##1 sys_rst_n [*1];
    endproperty
    a_rel: assert property (p_rel) else $error("reset release timing wrong");

    property p_scan_pull;
        @(posedge clk) disable iff (!nrst)
        scan_en |-> gp_pull_en[TCK_POS] && gp_pull_en[TMS_POS] && gp_pull_en[TDI_POS];
    endproperty
    a_scan_pull: assert property (p_scan_pull) else $error("scan pull-up missing");

    property p_tdo;
        @(posedge clk) disable iff (!nrst)
        !tap_shift |-> tdo_oe_n;
    endproperty
    a_tdo: assert property (p_tdo) else $error("tdo driven outside shift");
endmodule // smr_ctrl
`default_nettype wire

// ### verif/smr_rst_src.sv
`timescale 1ns/1ns
`default_nettype none
// board reset source: holds the pin low for a fixed time, clock or not
module smr_rst_src #(
    parameter int LOW_NS = 200
)(
    input wire logic go,
    output logic ext_rst_n
);
    initial ext_rst_n = 1'b1;
    // timed in ns, not cycles, so it works while the system clock is stopped
    always @(posedge go)
    begin
        ext_rst_n = 1'b0;
        #(LOW_NS);
        ext_rst_n = 1'b1;
    end
endmodule // smr_rst_src
`default_nettype wire

// ### verif/sleep_mode_reset_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module sleep_mode_reset_control_test;
    import smr_pkg::*;
    logic clk, clk_run, nrst, rst_go, ext_rst_n, sleep_req, sleep_en;
    logic [2:0] sleep_mode;
    logic [3:0] irqs;
    logic [31:0] port_dir, port_out, port_pull, gp_o, gp_oe_n, gp_pull_en;
    logic scan_en, tap_shift, tdo_data, tdo_o, tdo_oe_n, sleeping, sys_rst_n;
    logic cpu_clk_en, io_clk_en, adc_clk_en, asy_clk_en, osc_en;
    logic [5:0] st;
    int miscompares;
    int checks_done;
    // per-mode tables: code, gating while asleep, wake source, ignored source
    logic [2:0] mcode [6] = '{SM_IDLE, SM_ADCNR, SM_PDOWN, SM_PSAVE, SM_STBY, SM_XSTBY};
    logic [5:0] slp_exp [6] = '{6'h1F, 6'h0F, 6'h01, 6'h05, 6'h03, 6'h07};
    logic [3:0] wk [6] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h8, 4'h4};
    logic [3:0] nw [6] = '{4'h2, 4'h1, 4'h4, 4'h2, 4'h4, 4'h2};

    // packed view of enables: cpu io adc asy osc sleeping
    assign st = {cpu_clk_en, io_clk_en, adc_clk_en, asy_clk_en, osc_en, sleeping};

    // clock can be stopped to prove the reset paths need no clock
    initial
    begin
        clk = 1'b0;
        forever
        begin
            #20;
            if (clk_run)
                clk = ~clk;
        end
    end

    smr_ctrl dut (
        .clk(clk), .nrst(nrst), .ext_rst_n(ext_rst_n), .sleep_req(sleep_req),
        .sleep_en(sleep_en), .sleep_mode(sleep_mode), .irq_ext(irqs[3]),
        .irq_async(irqs[2]), .irq_adc(irqs[1]), .irq_any(irqs[0]),
        .port_dir(port_dir), .port_out(port_out), .port_pull(port_pull),
        .scan_en(scan_en), .tap_shift(tap_shift), .tdo_data(tdo_data),
        .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en),
        .asy_clk_en(asy_clk_en), .osc_en(osc_en), .sleeping(sleeping),
        .sys_rst_n(sys_rst_n), .gp_o(gp_o), .gp_oe_n(gp_oe_n),
        .gp_pull_en(gp_pull_en), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n)
    );

    smr_rst_src #(.LOW_NS(200)) rst_src (
        .go(rst_go),
        .ext_rst_n(ext_rst_n)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one-cycle sleep request pulse, driven on the falling edge
    task automatic req_sleep(input logic en, input logic [2:0] code);
        sleep_en = en;
        sleep_mode = code;
        sleep_req = 1'b1;
        @(negedge clk);
        sleep_req = 1'b0;
        // let an edge pass so a following call never re-raises the strobe at once
        @(negedge clk);
    endtask

    // disabled sleep and reserved codes must leave the core running
    task automatic t_refuse();
        req_sleep(1'b0, SM_PDOWN);
        chk(st, 6'h3E, "sleep with enable low");
        req_sleep(1'b1, 3'h4);
        chk(st, 6'h3E, "reserved code 4");
        req_sleep(1'b1, 3'h5);
        chk(st, 6'h3E, "reserved code 5");
    endtask

    // every mode back to back: gating, ignored irq, wake, restart length
    task automatic t_modes();
        for (int i = 0; i < 6; i++)
        begin
            req_sleep(1'b1, mcode[i]);
            sleep_mode = ~mcode[i];
            chk(st, slp_exp[i], "gating asleep");
            irqs = nw[i];
            repeat (3) @(negedge clk);
            chk(st, slp_exp[i], "gating with foreign irq");
            irqs = wk[i];
            @(negedge clk);
            irqs = 4'h0;
            if (i == 2 || i == 3)
            begin
                chk(st, 6'h06, "oscillator restart");
                repeat (24) @(negedge clk);
                chk(cpu_clk_en, 1'b0, "restart not yet over");
                @(negedge clk);
            end
            chk(st, 6'h3E, "back to run");
        end
    endtask

    // pads in run and the scan output enable table
    task automatic t_pins();
        @(negedge clk);
        port_dir = 32'h0F0F00FF;
        port_out = 32'hA5A5A5A5;
        port_pull = 32'h0000FF00;
        scan_en = 1'b1;
        #1;
        chk(gp_oe_n, ~port_dir, "pad enables in run");
        chk(gp_o, port_out, "pad data in run");
        // input pulls on the low inputs plus the three scan pins
        chk(gp_pull_en, 32'h002CFF00, "input and scan pulls in run");
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            {scan_en, tap_shift} = k[1:0];
            tdo_data = k[0];
            #1;
            chk(tdo_oe_n, (k == 3) ? 32'h0 : 32'h1, "tdo enable");
            if (k == 3)
                chk(tdo_o, tdo_data, "tdo data");
        end
    endtask

    // board reset with the clock running while in standby; release takes two edges
    task automatic t_run_reset();
        @(negedge clk);
        req_sleep(1'b1, SM_STBY);
        rst_go = 1'b1;
        @(negedge clk);
        rst_go = 1'b0;
        chk(gp_oe_n, 32'hFFFFFFFF, "pins tristate in running reset");
        chk(sys_rst_n, 1'b0, "reset with clock running");
        chk(st, 6'h06, "sleep dropped in reset");
        // pin rises on a falling edge; step off it before counting edges
        wait (ext_rst_n);
        #10;
        @(negedge clk);
        chk(sys_rst_n, 1'b0, "running release after one edge");
        @(negedge clk);
        chk(sys_rst_n, 1'b1, "running release at second edge");
        @(negedge clk);
        chk(st, 6'h3E, "run after running reset");
    endtask

    // board reset in power-down with the clock stopped, then sync release
    task automatic t_clockless_reset();
        port_dir = 32'hFFFFFFFF;
        req_sleep(1'b1, SM_PDOWN);
        chk(sleeping, 1'b1, "asleep before reset");
        clk_run = 1'b0;
        rst_go = 1'b1;
        #5;
        chk(gp_oe_n, 32'hFFFFFFFF, "pins tristate in reset");
        chk(gp_pull_en, SCAN_PULL_MASK, "only scan pulls in reset");
        chk(sys_rst_n, 1'b0, "reset without clock");
        chk(st, 6'h06, "enables in reset");
        rst_go = 1'b0;
        #300;
        clk_run = 1'b1;
        @(negedge clk);
        chk(sys_rst_n, 1'b0, "release after one edge");
        @(negedge clk);
        chk(sys_rst_n, 1'b1, "release at second edge");
        // enables follow the released reset one edge later
        chk(st, 6'h06, "enables one edge behind release");
        @(negedge clk);
        chk(st, 6'h3E, "run after reset");
    endtask

    // main sequence
    initial
    begin
        clk_run = 1'b1;
        nrst = 1'b0;
        rst_go = 1'b0;
        sleep_req = 1'b0;
        sleep_en = 1'b1;
        sleep_mode = SM_IDLE;
        irqs = 4'h0;
        port_dir = 32'hFFFFFFFF;
        port_out = 32'h0;
        port_pull = 32'h0;
        scan_en = 1'b0;
        tap_shift = 1'b0;
        tdo_data = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (3) @(negedge clk);
        chk(gp_oe_n, 32'hFFFFFFFF, "pins in power-on reset");
        chk(gp_pull_en, 32'h0, "no pulls in reset");
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        t_refuse();
        t_modes();
        t_pins();
        t_run_reset();
        t_clockless_reset();
        tally_and_finish();
    end

    // a hang costs far more than the 130 or so cycles the tests need
    initial
    begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule // sleep_mode_reset_control_test
`default_nettype wire
